// [design/pcd_pkg.sv]
// Shared constants, carriers and modes of the programmable pad cell.
// Assumes one system clock; every capture and launch clock arrives as a one-cycle enable strobe.
package pcd_pkg;

  // ****************************************************************
  // Input delay line
  // ****************************************************************
  localparam int DLY_W = 3;
  localparam int DLY_TAPS = 8;
  localparam logic [DLY_W-1:0] DLY_NONE = 3'h0;

  // ****************************************************************
  // Inversion mask positions, one per path entering the cell
  // ****************************************************************
  localparam int INV_W = 9;
  localparam int INV_PAD = 0;
  localparam int INV_O1 = 1;
  localparam int INV_O2 = 2;
  localparam int INV_T1 = 3;
  localparam int INV_T2 = 4;
  localparam int INV_CAP_A = 5;
  localparam int INV_CAP_B = 6;
  localparam int INV_LAUNCH_A = 7;
  localparam int INV_LAUNCH_B = 8;

  // ****************************************************************
  // Two-entry receive buffer
  // ****************************************************************
  localparam int BUF_DEPTH = 2;
  localparam logic [1:0] BUF_FULL = 2'h2;
  localparam logic [1:0] BUF_EMPTY = 2'h0;
  localparam logic [1:0] BUF_ONE = 2'h1;

  typedef struct packed {
    logic first;
    logic second;
  } pcd_pair_s;

  localparam pcd_pair_s PAIR_RST = 2'h0;

  typedef struct packed {
    logic [DLY_W-1:0] delay_taps;
    logic in_latch;
    logic out_latch;
    logic oe_latch;
    logic out_reg_sel;
    logic oe_reg_sel;
    logic ddr_out;
    logic cascade;
    logic [INV_W-1:0] inv;
  } pcd_cfg_s;

  typedef enum logic [1:0] {
    PH_FIRST = 2'b01,
    PH_SECOND = 2'b10
  } pcd_phase_e;

endpackage

// [design/pcd_pad_cell.sv]
// Programmable pad cell: input, output and output-enable paths with paired storage elements.
// Assumes the capture and launch strobes are on clk_i; the pad input is asynchronous.
//
// Behaviour
// - Pad input passes optional delay to a direct line, and to two captured lines.
// - Output and enable paths each own a storage pair, register or latch; the input pair is always registered, in_latch only affects the cascade slave.
// - Fabric output bits reach the pad directly or through their storage pair.
// - Fabric enable bits, direct or stored, decide when the pad driver floats.
// - Every entering path, controls included, has an inversion option absorbed in the cell.
// - An input-only cell has no output path and no output logic.
// - Cascade re-registers the second captured bit on capture clock A.
// - DDR output stores bit one on launch A, bit two on launch B, then muxes.
// - No edge alignment option; DDR output acts as a plain register pair.
`timescale 1ns/1ns
module pcd_pad_cell #(
  parameter bit INPUT_ONLY = 1'b0
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire pcd_pkg::pcd_cfg_s cfg_i,
  input wire logic pad_i,
  output logic pad_o,
  output logic pad_oe_o,
  input wire pcd_pkg::pcd_pair_s out_bits_i,
  input wire pcd_pkg::pcd_pair_s en_bits_i,
  input wire logic cap_a_i,
  input wire logic cap_b_i,
  input wire logic launch_a_i,
  input wire logic launch_b_i,
  output logic direct_in_o,
  output pcd_pkg::pcd_pair_s rx_o,
  output logic rx_valid_o,
  input wire logic rx_ready_i,
  output logic cap_ready_o
);
  import pcd_pkg::*;

  // Storage element seen from outside: a latch is transparent while its gate is open
  function automatic logic se_view(input logic latch, input logic gate, input logic d, input logic q);
    se_view = (latch && gate) ? d : q;
  endfunction

  function automatic logic se_next(input logic gate, input logic d, input logic q);
    se_next = gate ? d : q;
  endfunction

  // ****************************************************************
  // Pad synchroniser and programmable delay
  // ****************************************************************
  logic pad_meta_q;
  logic pad_sync_q;
  logic [DLY_TAPS-2:0] dly_q;
  logic din;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pad_meta_q <= 1'b0;
      pad_sync_q <= 1'b0;
    end else begin
      pad_meta_q <= pad_i;
      pad_sync_q <= pad_meta_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      dly_q <= '0;
    end else begin
      dly_q <= {dly_q[DLY_TAPS-3:0], pad_sync_q ^ cfg_i.inv[INV_PAD]};
    end
  end

  always_comb begin
    if (cfg_i.delay_taps == DLY_NONE) begin
      din = pad_sync_q ^ cfg_i.inv[INV_PAD];
    end else begin
      din = dly_q[cfg_i.delay_taps - 3'h1];
    end
  end

  assign direct_in_o = din;

  // ****************************************************************
  // Input storage pair and cascade slave
  // ****************************************************************
  logic cap_a_eff;
  logic cap_b_eff;
  logic iq1_q;
  logic iq2_q;
  logic slave_q;
  logic push_q;
  logic [1:0] count_q;

  // A full buffer freezes capture so no received pair is overwritten
  assign cap_ready_o = ({1'b0, push_q} + count_q) < BUF_FULL;
  assign cap_a_eff = (cap_a_i ^ cfg_i.inv[INV_CAP_A]) && cap_ready_o;
  assign cap_b_eff = (cap_b_i ^ cfg_i.inv[INV_CAP_B]) && cap_ready_o;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      iq1_q <= 1'b0;
      iq2_q <= 1'b0;
    end else begin
      iq1_q <= se_next(cap_a_eff, din, iq1_q);
      iq2_q <= se_next(cap_b_eff, din, iq2_q);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      slave_q <= 1'b0;
    end else if (cfg_i.cascade && cap_a_eff) begin
      slave_q <= se_view(cfg_i.in_latch, cap_b_eff, din, iq2_q);
    end
  end

  // Pair is complete one cycle after its closing strobe
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      push_q <= 1'b0;
    end else begin
      push_q <= cfg_i.cascade ? cap_a_eff : cap_b_eff;
    end
  end

  // ****************************************************************
  // Two-entry receive buffer
  // ****************************************************************
  pcd_pair_s buf_q [BUF_DEPTH];
  logic wr_ptr_q;
  logic rd_ptr_q;
  logic pop;
  pcd_pair_s push_data;

  assign push_data.first = iq1_q;
  assign push_data.second = cfg_i.cascade ? slave_q : iq2_q;
  assign rx_valid_o = count_q != BUF_EMPTY;
  assign pop = rx_valid_o && rx_ready_i;
  assign rx_o = buf_q[rd_ptr_q];

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      buf_q[0] <= PAIR_RST;
      buf_q[1] <= PAIR_RST;
      wr_ptr_q <= 1'b0;
    end else if (push_q) begin
      buf_q[wr_ptr_q] <= push_data;
      wr_ptr_q <= ~wr_ptr_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rd_ptr_q <= 1'b0;
      count_q <= BUF_EMPTY;
    end else begin
      if (pop) begin
        rd_ptr_q <= ~rd_ptr_q;
      end
      count_q <= count_q + {1'b0, push_q} - {1'b0, pop};
    end
  end

  // ****************************************************************
  // Output and enable paths
  // ****************************************************************
  logic launch_a_eff;
  logic launch_b_eff;
  logic o1_in;
  logic o2_in;
  logic t1_in;
  logic t2_in;
  logic o1_q;
  logic o2_q;
  logic t1_q;
  logic t2_q;
  pcd_phase_e phase_q;
  logic data_sel;
  logic hiz_sel;

  assign launch_a_eff = launch_a_i ^ cfg_i.inv[INV_LAUNCH_A];
  assign launch_b_eff = launch_b_i ^ cfg_i.inv[INV_LAUNCH_B];
  assign o1_in = out_bits_i.first ^ cfg_i.inv[INV_O1];
  assign o2_in = out_bits_i.second ^ cfg_i.inv[INV_O2];
  assign t1_in = en_bits_i.first ^ cfg_i.inv[INV_T1];
  assign t2_in = en_bits_i.second ^ cfg_i.inv[INV_T2];

  generate
    if (INPUT_ONLY) begin : g_no_out
      // No output logic at all; the pad is never driven
      assign o1_q = 1'b0;
      assign o2_q = 1'b0;
      assign t1_q = 1'b1;
      assign t2_q = 1'b1;
      assign phase_q = PH_FIRST;
      assign data_sel = 1'b0;
      assign hiz_sel = 1'b1;
      assign pad_o = 1'b0;
      assign pad_oe_o = 1'b0;
    end else begin : g_out
      always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
          o1_q <= 1'b0;
          o2_q <= 1'b0;
        end else begin
          o1_q <= se_next(launch_a_eff, o1_in, o1_q);
          o2_q <= se_next(launch_b_eff, o2_in, o2_q);
        end
      end

      // Enable pair resets to the floating state so the pad stays quiet
      always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
          t1_q <= 1'b1;
          t2_q <= 1'b1;
        end else begin
          t1_q <= se_next(launch_a_eff, t1_in, t1_q);
          t2_q <= se_next(launch_b_eff, t2_in, t2_q);
        end
      end

      // Plain register pair muxing; there is no alignment of one launch edge to the other
      always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
          phase_q <= PH_FIRST;
        end else if (launch_b_eff) begin
          phase_q <= PH_SECOND;
        end else if (launch_a_eff) begin
          phase_q <= PH_FIRST;
        end
      end

      always_comb begin
        if (cfg_i.ddr_out) begin
          unique case (phase_q)
            PH_FIRST: data_sel = se_view(cfg_i.out_latch, launch_a_eff, o1_in, o1_q);
            PH_SECOND: data_sel = se_view(cfg_i.out_latch, launch_b_eff, o2_in, o2_q);
          endcase
        end else if (cfg_i.out_reg_sel) begin
          data_sel = se_view(cfg_i.out_latch, launch_a_eff, o1_in, o1_q);
        end else begin
          data_sel = o1_in;
        end
      end

      always_comb begin
        if (cfg_i.oe_reg_sel && cfg_i.ddr_out) begin
          unique case (phase_q)
            PH_FIRST: hiz_sel = se_view(cfg_i.oe_latch, launch_a_eff, t1_in, t1_q);
            PH_SECOND: hiz_sel = se_view(cfg_i.oe_latch, launch_b_eff, t2_in, t2_q);
          endcase
        end else if (cfg_i.oe_reg_sel) begin
          hiz_sel = se_view(cfg_i.oe_latch, launch_a_eff, t1_in, t1_q);
        end else begin
          hiz_sel = t1_in;
        end
      end

      assign pad_o = data_sel;
      assign pad_oe_o = ~hiz_sel;
    end
  endgenerate

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  delay_bypass_a: assert property ((cfg_i.delay_taps == DLY_NONE) |->
      direct_in_o == (pad_sync_q ^ cfg_i.inv[INV_PAD]))
    else $error("direct line not equal to undelayed pad");

  first_capture_a: assert property ($stable(cfg_i) && cap_a_eff |=> iq1_q == $past(din))
    else $error("first captured bit not taken on capture A");

  capture_hold_a: assert property (!cap_a_eff && !cap_b_eff |=> $stable(iq1_q) && $stable(iq2_q))
    else $error("input storage changed without a strobe");

  out_direct_a: assert property (!INPUT_ONLY && !cfg_i.ddr_out && !cfg_i.out_reg_sel |->
      pad_o == (out_bits_i.first ^ cfg_i.inv[INV_O1]))
    else $error("direct output path broken");

  oe_direct_a: assert property (!INPUT_ONLY && !cfg_i.oe_reg_sel |->
      pad_oe_o == !(en_bits_i.first ^ cfg_i.inv[INV_T1]))
    else $error("direct enable path broken");

  invert_absorb_a: assert property (!INPUT_ONLY && !cfg_i.ddr_out && !cfg_i.out_reg_sel &&
      cfg_i.inv[INV_O1] |-> pad_o != out_bits_i.first)
    else $error("output inversion not applied");

  input_only_a: assert property (INPUT_ONLY |-> !pad_oe_o && !pad_o)
    else $error("input-only cell drives the pad");

  cascade_retime_a: assert property ($stable(cfg_i) && cfg_i.cascade && cap_a_eff && !cap_b_eff |->
      ##1 slave_q == $past(iq2_q) ##1 ((rx_o.second == $past(slave_q)) || (count_q != BUF_ONE)))
    else $error("cascade slave did not retime second bit");

  ddr_second_a: assert property (!INPUT_ONLY && $stable(cfg_i) && cfg_i.ddr_out && !cfg_i.out_latch &&
      launch_b_eff && !launch_a_eff |=> phase_q == PH_SECOND && pad_o == o2_q && o2_q == $past(o2_in))
    else $error("second ddr bit not on the pad after launch B");

  ddr_first_a: assert property (!INPUT_ONLY && $stable(cfg_i) && cfg_i.ddr_out && !cfg_i.out_latch &&
      launch_a_eff && !launch_b_eff |=> pad_o == $past(o1_in))
    else $error("first ddr bit not on the pad after launch A");

  buf_bound_a: assert property (count_q <= BUF_FULL && (count_q != BUF_FULL || !cap_ready_o))
    else $error("receive buffer overrun");

  cascade_pair_c: cover property (cfg_i.cascade && cap_a_eff ##2 rx_valid_o);
  ddr_toggle_c: cover property (cfg_i.ddr_out && launch_a_eff ##1 launch_b_eff ##1 launch_a_eff);
  buf_stall_c: cover property (count_q == BUF_FULL && !rx_ready_i ##1 !cap_ready_o);

endmodule

// [sim/pcd_pad_model.sv]
// Far side of the pad: an outside driver and the resolved wire level.
// Assumes clk_i is the cell's system clock.
`timescale 1ns/1ns
module pcd_pad_model (
  input wire logic clk_i,
  input wire logic drv_i,
  input wire logic oe_i,
  input wire logic ext_drive_i,
  input wire logic ext_val_i,
  output logic level_o
);
  logic float_q = 1'b0;
  // No pull on this wire: a floating pad toggles so a stale level never passes
  always_ff @(posedge clk_i) begin
    float_q <= ~float_q;
  end
  always_comb begin
    if (oe_i) begin
      level_o = drv_i;
    end else if (ext_drive_i) begin
      level_o = ext_val_i;
    end else begin
      level_o = float_q;
    end
  end
endmodule

// [sim/test_programmable_io_cell_ddr.sv]
// Bench for the pad cell: input capture, buffer, output paths and the input-only variant.
// Assumes package, cell and pad model are compiled first.
`timescale 1ns/1ns
module test_programmable_io_cell_ddr;
  import pcd_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  pcd_cfg_s cfg = '0;
  pcd_pair_s out_bits = 2'h0;
  pcd_pair_s en_bits = 2'h2;
  pcd_pair_s rx;
  logic cap_a = 1'b0, cap_b = 1'b0, la = 1'b0, lb = 1'b0, rx_ready = 1'b0;
  logic ext_drive = 1'b1, ext_val = 1'b0;
  logic pad, pad_oe, din, rx_valid, cap_ready, level, pad2, oe2;
  int errors = 0;
  int checks = 0;
  always #10 clk_i = ~clk_i;
  // ****************************************************************
  // Instances
  // ****************************************************************
  pcd_pad_cell dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .cfg_i(cfg), .pad_i(level), .pad_o(pad),
    .pad_oe_o(pad_oe), .out_bits_i(out_bits), .en_bits_i(en_bits), .cap_a_i(cap_a), .cap_b_i(cap_b),
    .launch_a_i(la), .launch_b_i(lb), .direct_in_o(din), .rx_o(rx), .rx_valid_o(rx_valid),
    .rx_ready_i(rx_ready), .cap_ready_o(cap_ready));
  pcd_pad_cell #(.INPUT_ONLY(1'b1)) dut_in_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .cfg_i(cfg),
    .pad_i(level), .pad_o(pad2), .pad_oe_o(oe2), .out_bits_i(out_bits), .en_bits_i(en_bits),
    .cap_a_i(cap_a), .cap_b_i(cap_b), .launch_a_i(la), .launch_b_i(lb), .direct_in_o(),
    .rx_o(), .rx_valid_o(), .rx_ready_i(rx_ready), .cap_ready_o());
  pcd_pad_model far_u (.clk_i(clk_i), .drv_i(pad), .oe_i(pad_oe), .ext_drive_i(ext_drive),
    .ext_val_i(ext_val), .level_o(level));
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic tick(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic restart();
    cfg = '0;
    out_bits = 2'h0;
    en_bits = 2'h2;
    rx_ready = 1'b0;
    rst_n_i = 1'b0;
    tick(3);
    rst_n_i = 1'b1;
  endtask
  // Pad level needs two sync edges before a strobe sees it (taps 0)
  task automatic cap(input logic v, input logic b_side);
    ext_val = v;
    tick(4);
    if (b_side) begin
      cap_b = 1'b1;
    end else begin
      cap_a = 1'b1;
    end
    tick(1);
    cap_a = 1'b0;
    cap_b = 1'b0;
  endtask
  task automatic pop(input logic a, input logic b);
    int n;
    n = 0;
    while (rx_valid !== 1'b1 && n < 20) begin
      tick(1);
      n++;
    end
    if (n == 20) begin
      errors++;
      wrap_up();
    end else begin
      chk("rx_first", a, rx.first);
      chk("rx_second", b, rx.second);
      rx_ready = 1'b1;
      tick(1);
      rx_ready = 1'b0;
    end
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_delay();
    restart();
    cfg.delay_taps = 3'h3;
    ext_val = 1'b1;
    tick(2);
    chk("direct_early", 1'b0, din);
    tick(4);
    chk("direct_late", 1'b1, din);
    $display("test delay done");
  endtask
  task automatic t_capture();
    for (int i = 0; i < 2; i++) begin
      restart();
      cfg.inv[INV_PAD] = i[0];
      cap(1'b1, 1'b0);
      cap(1'b0, 1'b1);
      pop(~i[0], i[0]);
    end
    restart();
    cfg.cascade = 1'b1;
    cap(1'b0, 1'b1);
    cap(1'b1, 1'b0);
    pop(1'b1, 1'b0);
    $display("test capture done");
  endtask
  task automatic t_buffer();
    restart();
    cap(1'b1, 1'b0);
    cap(1'b0, 1'b1);
    cap(1'b0, 1'b0);
    cap(1'b1, 1'b1);
    tick(3);
    chk("cap_ready_full", 1'b0, cap_ready);
    cap(1'b1, 1'b0);
    cap(1'b1, 1'b1);
    pop(1'b1, 1'b0);
    pop(1'b0, 1'b1);
    tick(3);
    chk("rx_valid_empty", 1'b0, rx_valid);
    chk("cap_ready_empty", 1'b1, cap_ready);
    $display("test buffer done");
  endtask
  task automatic t_out_direct();
    restart();
    en_bits = 2'h0;
    for (int i = 0; i < 4; i++) begin
      out_bits.first = i[0];
      cfg.inv[INV_O1] = i[1];
      tick(1);
      chk("pad_direct", i[0] ^ i[1], pad);
      chk("oe_direct", 1'b1, pad_oe);
      chk("pad_in_only", 1'b0, pad2);
      chk("oe_in_only", 1'b0, oe2);
    end
    cfg.inv[INV_T1] = 1'b1;
    en_bits.first = 1'b1;
    tick(1);
    chk("oe_inverted", 1'b1, pad_oe);
    en_bits.first = 1'b0;
    tick(1);
    chk("oe_float", 1'b0, pad_oe);
    $display("test out direct done");
  endtask
  task automatic t_out_reg();
    restart();
    cfg.out_reg_sel = 1'b1;
    cfg.oe_reg_sel = 1'b1;
    out_bits.first = 1'b1;
    en_bits.first = 1'b0;
    tick(1);
    chk("pad_before_launch", 1'b0, pad);
    chk("oe_before_launch", 1'b0, pad_oe);
    la = 1'b1;
    tick(1);
    chk("pad_reg", 1'b1, pad);
    chk("oe_reg", 1'b1, pad_oe);
    la = 1'b0;
    out_bits.first = 1'b0;
    tick(2);
    chk("pad_reg_hold", 1'b1, pad);
    // Inverted launch strobe: a high level is idle, a low level launches
    cfg.inv[INV_LAUNCH_A] = 1'b1;
    la = 1'b1;
    tick(1);
    chk("pad_launch_idle", 1'b1, pad);
    la = 1'b0;
    tick(1);
    chk("pad_launch_inv", 1'b0, pad);
    $display("test out reg done");
  endtask
  task automatic t_ddr();
    restart();
    cfg.out_reg_sel = 1'b1;
    cfg.ddr_out = 1'b1;
    en_bits = 2'h0;
    for (int i = 0; i < 2; i++) begin
      out_bits = {~i[0], i[0]};
      la = 1'b1;
      tick(1);
      chk("ddr_first", ~i[0], pad);
      la = 1'b0;
      lb = 1'b1; // Second bit already stands for the launch B edge
      tick(1);
      chk("ddr_second", i[0], pad);
      lb = 1'b0;
    end
    $display("test ddr done");
  endtask
  task automatic t_latch();
    restart();
    cfg.out_reg_sel = 1'b1;
    cfg.out_latch = 1'b1;
    cfg.oe_reg_sel = 1'b1;
    cfg.oe_latch = 1'b1;
    la = 1'b1;
    out_bits.first = 1'b1;
    tick(1);
    chk("latch_open_1", 1'b1, pad);
    chk("oe_latch_open_float", 1'b0, pad_oe);
    out_bits.first = 1'b0;
    en_bits.first = 1'b0;
    tick(1);
    chk("latch_open_0", 1'b0, pad);
    chk("oe_latch_open_drive", 1'b1, pad_oe);
    la = 1'b0;
    tick(1);
    out_bits.first = 1'b1;
    en_bits.first = 1'b1;
    tick(2);
    chk("latch_closed", 1'b0, pad);
    chk("oe_latch_closed", 1'b1, pad_oe);
    $display("test latch done");
  endtask
  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  initial begin
    restart();
    chk("rx_valid_rst", 1'b0, rx_valid);
    chk("cap_ready_rst", 1'b1, cap_ready);
    chk("oe_rst", 1'b0, pad_oe);
    t_delay();
    t_capture();
    t_buffer();
    t_out_direct();
    t_out_reg();
    t_ddr();
    t_latch();
    wrap_up();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    errors++;
    wrap_up();
  end
endmodule
